/* File: rtl/sfscr_pkg.sv */
package sfscr_pkg;

  // Status byte layout, bit7 down to bit0
  typedef struct packed {
    logic       lock;
    logic       quad;
    logic [3:0] level;
    logic       write_enable_latch;
    logic       busy;
  } sfscr_status_t;

  // Configuration byte layout, bit7 down to bit0
  typedef struct packed {
    logic [1:0] dummy;
    logic       wide;
    logic       rsvd;
    logic       origin;
    logic [2:0] drive;
  } sfscr_config_t;

  // Frame states, Gray coded along opcode -> data
  typedef enum logic [1:0] {
    ST_OPCODE  = 2'b00,
    ST_DATAOUT = 2'b01,
    ST_DATAIN  = 2'b11,
    ST_IGNORE  = 2'b10
  } sfscr_state_t;

  // Reset values
  localparam logic [7:0] STATUS_RESET     = 8'h00;
  localparam logic [2:0] DRIVE_30_OHM     = 3'h7;
  localparam logic [1:0] DUMMY_RESET      = 2'h0;
  localparam logic [1:0] DUMMY_HIGH_FREQ  = 2'h3;

  // Framing counts
  localparam logic [4:0] SPI_OPCODE_LAST  = 5'h07;
  localparam logic [4:0] QPI_OPCODE_LAST  = 5'h01;
  localparam logic [4:0] UNIT_CNT_MAX     = 5'h1f;
  localparam logic [6:0] DATA_BITS_SHORT  = 7'h08;
  localparam logic [6:0] DATA_BITS_LONG   = 7'h10;
  localparam logic [2:0] SPI_BIT_LAST     = 3'h7;
  localparam logic [1:0] ID_BYTE_LAST     = 2'h2;

  // Fixed opcode and timing base
  localparam logic [7:0] QUAD_ID_OPCODE   = 8'hAF;
  localparam int         CLK_PERIOD_NS    = 8;

endpackage

/* File: rtl/sfscr_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - After the quad identify opcode, ID bits change on each falling clock, MSB first.
// - ID stream sends maker, type, density bytes repeatedly until chip select rises.
// - Status byte is readable at any time, even while busy.
// - Configuration byte is readable at any time, even while busy.
// - Opcodes take eight single-line clocks, or two nibble clocks in quad mode.
// - Status bit0 is the volatile busy flag, high during program, erase, status write.
// - Status bit1 write-enable latch gates program, erase and status write acceptance.
// - Program or erase aimed at the protected area is silently ignored.
// - Status bits 5..2 hold protect levels, default zero, changed only by status write.
// - Chip erase runs only when all four protect levels are zero.
// - Status bit6 quad enable disables write-protect, reset pin and hardware protection.
// - Lock bit7 with write-protect low refuses status writes.
// - Config bits 7..6 dummy select, reset 00, written by status write.
// - Without high-frequency support, writing dummy select 11 leaves it unchanged.
// - Config bits 2..0 drive strength, default 30 ohm, written by status write.
// - Config bit3 protect origin is one-time settable to bottom by status write.
// - Config bit5 wide addressing set by enter, cleared by exit or reset.
// - Status write executes only if chip select rises after exactly 8 or 16 bits.
// - Busy stays high for the write time, then busy and latch clear.
module sfscr_regs
  import sfscr_pkg::*;
#(
  parameter logic [7:0] STATUS_READ_OPCODE = 8'h05,
  parameter logic [7:0] CONFIG_READ_OPCODE = 8'h15,
  parameter logic [7:0] STATUS_WRITE_OPCODE = 8'h01,
  parameter logic [7:0] WRITE_ENABLE_OPCODE = 8'h06,
  parameter logic [7:0] WRITE_DISABLE_OPCODE = 8'h04,
  parameter logic [7:0] ENTER_WIDE_OPCODE  = 8'hB7,
  parameter logic [7:0] EXIT_WIDE_OPCODE   = 8'hE9,
  parameter logic [7:0] MAKER_CODE         = 8'h5A, // Arbitrary value
  parameter logic [7:0] TYPE_CODE          = 8'h11, // Arbitrary value
  parameter logic [7:0] DENSITY_CODE       = 8'h22, // Arbitrary value
  parameter bit         HIGH_FREQ          = 1'b0,
  parameter int         STATUS_WRITE_TIME_US = 40
) (
  // Clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          resetn_in,
  // Serial link pins
  input  wire logic          sclk_in,
  input  wire logic          cs_n_in,
  input  wire logic [3:0]    sio_in,
  output logic      [3:0]    sio_out,
  output logic      [3:0]    sio_oe_out,
  input  wire logic          quad_mode_in,
  input  wire logic          reset_pin_n_in,
  // Array engine handshake
  input  wire logic          pe_req_in,
  input  wire logic          pe_chip_erase_in,
  input  wire logic          pe_in_protected_in,
  input  wire logic          pe_done_in,
  output logic               pe_start_out,
  // Register views
  output sfscr_status_t      status_out,
  output sfscr_config_t      config_out,
  output logic               hardware_protect_mode_out
);

  localparam int TW_CYCLES = (STATUS_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [19:0] TW_LOAD = 20'(TW_CYCLES);
  localparam logic [19:0] TW_ONE  = 20'h0_0001;

  // Timer width and assertion window need a sane write time
  if (TW_CYCLES < 9 || TW_CYCLES > 20'hF_FFFF) begin : g_bad_tw
    $error("status write time out of range");
  end

  // Pin synchronisers; stage one feeds stage two only
  logic       sclk_q1, sclk_q2, sclk_q3;
  logic       cs_q1, cs_q2, cs_q3;
  logic [3:0] sio_q1, sio_q2;
  logic       qpi_q1, qpi_q2, rpin_q1, rpin_q2;

  always_ff @(posedge sys_clk_in) begin
    sclk_q1 <= sclk_in;
    sclk_q2 <= sclk_q1;
    sclk_q3 <= sclk_q2;
    cs_q1   <= cs_n_in;
    cs_q2   <= cs_q1;
    cs_q3   <= cs_q2;
    sio_q1  <= sio_in;
    sio_q2  <= sio_q1;
    qpi_q1  <= quad_mode_in;
    qpi_q2  <= qpi_q1;
    rpin_q1 <= reset_pin_n_in;
    rpin_q2 <= rpin_q1;
  end

  // Frame state
  sfscr_state_t  state_reg;
  logic [4:0]    unit_cnt_reg;
  logic [15:0]   shift_reg;
  logic [7:0]    cmd_reg;
  logic [2:0]    ptr_reg;
  logic [1:0]    idx_reg;
  logic          drive_reg;
  logic [3:0]    sio_q_reg;
  sfscr_status_t status_reg;
  sfscr_config_t config_reg;
  logic [19:0]   tw_cnt_reg;
  logic          pe_busy_reg;

  // Edge and frame decode
  wire        qpi        = qpi_q2;
  wire        cs_low     = ~cs_q2;
  wire        sclk_rise  = sclk_q2 & ~sclk_q3 & cs_low;
  wire        sclk_fall  = ~sclk_q2 & sclk_q3 & cs_low;
  wire        cs_rise    = cs_q2 & ~cs_q3;
  wire [15:0] shift_next = qpi ? {shift_reg[11:0], sio_q2} : {shift_reg[14:0], sio_q2[0]};
  wire [4:0]  opc_last   = qpi ? QPI_OPCODE_LAST : SPI_OPCODE_LAST;
  wire        opc_done   = sclk_rise & (state_reg == ST_OPCODE) & (unit_cnt_reg == opc_last);
  wire [7:0]  opcode     = shift_next[7:0];
  wire        is_read    = (opcode == STATUS_READ_OPCODE) | (opcode == CONFIG_READ_OPCODE)
                         | (opcode == QUAD_ID_OPCODE);
  wire        busy       = status_reg.busy;

  // Opcode steers the rest of the frame
  sfscr_state_t state_after_opc;
  assign state_after_opc = is_read ? ST_DATAOUT :
                           (opcode == STATUS_WRITE_OPCODE) ? ST_DATAIN : ST_IGNORE;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || !cs_low) begin
      state_reg    <= ST_OPCODE;
      unit_cnt_reg <= 5'h00;
    end else if (opc_done) begin
      state_reg    <= state_after_opc;
      unit_cnt_reg <= 5'h00;
    end else if (sclk_rise && unit_cnt_reg != UNIT_CNT_MAX) begin
      unit_cnt_reg <= unit_cnt_reg + 5'h01;
    end
  end

  // Shifter and latched opcode
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      shift_reg <= 16'h0000;
      cmd_reg   <= 8'h00;
    end else begin
      if (sclk_rise) shift_reg <= shift_next;
      if (opc_done) cmd_reg <= opcode;
    end
  end

  // Readout source; live register values so reads work while busy
  logic [7:0] id_byte;
  assign id_byte = (idx_reg == 2'h0) ? MAKER_CODE :
                   (idx_reg == 2'h1) ? TYPE_CODE : DENSITY_CODE;
  wire [7:0] cur_byte = (cmd_reg == STATUS_READ_OPCODE) ? status_reg :
                        (cmd_reg == CONFIG_READ_OPCODE) ? config_reg : id_byte;
  wire       unit_last = qpi ? ptr_reg[0] : (ptr_reg == SPI_BIT_LAST);
  wire [1:0] idx_wrap  = (idx_reg == ID_BYTE_LAST) ? 2'h0 : idx_reg + 2'h1;
  wire [1:0] idx_next  = (cmd_reg == QUAD_ID_OPCODE) ? idx_wrap : 2'h0;
  wire [3:0] nibble    = ptr_reg[0] ? cur_byte[3:0] : cur_byte[7:4];
  wire [3:0] out_next  = qpi ? nibble : {2'b00, cur_byte[~ptr_reg], 1'b0};
  wire       out_step  = sclk_fall & (state_reg == ST_DATAOUT);

  // Output data changes on the falling clock, MSB first
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || !cs_low) begin
      drive_reg <= 1'b0;
      sio_q_reg <= 4'h0;
      ptr_reg   <= 3'h0;
      idx_reg   <= 2'h0;
    end else if (out_step) begin
      drive_reg <= 1'b1;
      sio_q_reg <= out_next;
      ptr_reg   <= unit_last ? 3'h0 : ptr_reg + 3'h1;
      if (unit_last) idx_reg <= idx_next;
    end
  end

  assign sio_out    = sio_q_reg;
  assign sio_oe_out = !drive_reg ? 4'h0 : (qpi ? 4'hF : 4'h2);

  // Status write qualification at frame end
  wire [6:0] data_bits = qpi ? {unit_cnt_reg, 2'b00} : {2'b00, unit_cnt_reg};
  wire       long_wr   = (data_bits == DATA_BITS_LONG);
  wire       len_ok    = (data_bits == DATA_BITS_SHORT) | long_wr;
  wire       wp_n      = sio_q2[2];
  wire       hw_lock   = status_reg.lock & ~wp_n & ~status_reg.quad;
  wire       sw_end    = cs_rise & (state_reg == ST_DATAIN);
  wire       sw_go     = sw_end & len_ok & status_reg.write_enable_latch & ~busy & ~hw_lock;
  sfscr_status_t new_st;
  sfscr_config_t new_cf;
  assign new_st = long_wr ? shift_reg[15:8] : shift_reg[7:0];
  assign new_cf = shift_reg[7:0];
  wire [1:0] dummy_wr = (new_cf.dummy == DUMMY_HIGH_FREQ && !HIGH_FREQ) ? config_reg.dummy
                                                                         : new_cf.dummy;

  // One-byte commands execute on chip select rise with no extra clocks
  wire simple_go = cs_rise & (state_reg == ST_IGNORE) & (unit_cnt_reg == 5'h00) & ~busy;
  wire do_wren   = simple_go & (cmd_reg == WRITE_ENABLE_OPCODE);
  wire do_wrdi   = simple_go & (cmd_reg == WRITE_DISABLE_OPCODE);
  wire do_enter  = simple_go & (cmd_reg == ENTER_WIDE_OPCODE);
  wire do_exit   = simple_go & (cmd_reg == EXIT_WIDE_OPCODE);
  wire pin_reset = ~rpin_q2 & ~status_reg.quad;
  wire tw_done   = (tw_cnt_reg == TW_ONE);

  // Array engine gate; protected targets vanish without a trace
  assign pe_start_out = pe_req_in & status_reg.write_enable_latch & ~busy & ~pe_in_protected_in
                      & (~pe_chip_erase_in | (status_reg.level == 4'h0));
  assign hardware_protect_mode_out = hw_lock;

  // Self-timed write cycle counter
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      tw_cnt_reg <= 20'h0_0000;
    end else if (sw_go) begin
      tw_cnt_reg <= TW_LOAD;
    end else if (tw_cnt_reg != 20'h0_0000) begin
      tw_cnt_reg <= tw_cnt_reg - TW_ONE;
    end
  end

  // Array engine busy; a new start wins over a done
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) pe_busy_reg <= 1'b0;
    else if (pe_start_out) pe_busy_reg <= 1'b1;
    else if (pe_done_in) pe_busy_reg <= 1'b0;
  end

  // Status byte; nonvolatile bits restart at zero as nothing is stored
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg.busy <= (tw_cnt_reg != 20'h0_0000 && !tw_done) | sw_go | pe_busy_reg | pe_start_out;
      if (sw_go) begin
        status_reg.lock  <= new_st.lock;
        status_reg.quad  <= new_st.quad;
        status_reg.level <= new_st.level;
      end
      if (tw_done || (pe_done_in && pe_busy_reg) || do_wrdi || pin_reset) status_reg.write_enable_latch <= 1'b0;
      if (do_wren) status_reg.write_enable_latch <= 1'b1;
    end
  end

  // Configuration byte
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      config_reg <= {DUMMY_RESET, 1'b0, 1'b0, 1'b0, DRIVE_30_OHM};
    end else begin
      if (sw_go && long_wr) begin
        config_reg.dummy  <= dummy_wr;
        config_reg.drive  <= new_cf.drive;
        config_reg.origin <= config_reg.origin | new_cf.origin;
      end
      if (do_exit || pin_reset) config_reg.wide <= 1'b0;
      if (do_enter) config_reg.wide <= 1'b1;
      config_reg.rsvd <= 1'b0;
    end
  end

  assign status_out = status_reg;
  assign config_out = config_reg;

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence seq_busy_run;
    status_reg.busy [*8];
  endsequence

  sequence seq_cycle_close;
    !status_reg.busy && !status_reg.write_enable_latch;
  endsequence

  AST_SW_BUSY: assert property (sw_go |=> seq_busy_run)
    else $error("busy did not hold after status write");
  AST_SW_CLOSE: assert property (tw_done && !pe_busy_reg && !pe_start_out |=> seq_cycle_close)
    else $error("busy or latch stayed set after write cycle");
  AST_PE_WEL: assert property (pe_start_out |-> status_reg.write_enable_latch && !status_reg.busy)
    else $error("array start without write enable");
  AST_PE_PROT: assert property (pe_in_protected_in |-> !pe_start_out)
    else $error("protected target started");
  AST_CHIP_ERASE: assert property (pe_start_out && pe_chip_erase_in |-> status_reg.level == 4'h0)
    else $error("chip erase with protection set");
  AST_LOCKED: assert property (sw_end && hw_lock |=> $stable(status_reg[7:2]))
    else $error("locked status byte changed");
  AST_BAD_LEN: assert property (sw_end && !len_ok |=> ##1 !status_reg.busy || pe_busy_reg)
    else $error("status write with bad length executed");
  AST_DUMMY: assert property (!HIGH_FREQ |-> config_reg.dummy != DUMMY_HIGH_FREQ)
    else $error("dummy select reached unsupported value");
  AST_RSVD: assert property (##1 config_reg.rsvd == 1'b0)
    else $error("reserved config bit set");
  AST_WIDE: assert property (do_enter |=> config_reg.wide)
    else $error("wide address flag not set");
  // Latch and busy must follow an accepted command, and readout a falling clock, on the very next edge
  AST_WEL_SET: assert property (do_wren |=> status_reg.write_enable_latch)
    else $error("write enable latch not set");
  AST_PE_BUSY: assert property (pe_start_out |=> status_reg.busy)
    else $error("busy not raised by array start");
  AST_OUT_DRIVE: assert property (out_step |=> drive_reg && sio_q_reg == $past(out_next))
    else $error("readout not driven on falling clock");

endmodule

/* File: verif/sfscr_host.sv */
`timescale 1ns/1ps
// Host controller model: frames commands, mode 0, link clock idles low
module sfscr_host (
  // Clock and mode
  input  wire logic       clk_in,
  input  wire logic       quad_in,
  input  wire logic       wp_n_in,
  input  wire logic [3:0] sio_in,
  // Link pins
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic [3:0]      sio_out,
  output logic [3:0]      sio_en_out
);
  logic [3:0] dat;
  logic       drv;

  // Write-protect pin stays driven in single-line mode
  assign sio_out    = quad_in ? dat : {1'b1, wp_n_in, 1'b1, dat[0]};
  assign sio_en_out = quad_in ? {4{drv}} : {1'b0, 1'b1, 1'b0, drv};

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    dat = 4'h0;
    drv = 1'b0;
  end

  // Half of the 64 ns link period, moves on falling system edges
  task half();
    repeat (4) @(negedge clk_in);
  endtask

  task xfer(input logic [7:0] op, input logic [15:0] wd, input int wbits, input int rclk,
            output logic [47:0] rd);
    logic [23:0] v;
    int          w;
    v = {op, wd};
    w = quad_in ? 4 : 1;
    rd = 48'h0;
    cs_n_out = 1'b0;
    drv = 1'b1;
    // Opcode and data MSB first, lines change only while the clock is low
    for (int i = 0; i < (8 + wbits) / w; i++) begin
      dat = quad_in ? v[23:20] : {3'h0, v[23]};
      v = v << w;
      half();
      sclk_out = 1'b1;
      half();
      sclk_out = 1'b0;
    end
    // Release the lines; device owns them from the first fall on
    drv = 1'b0;
    for (int i = 0; i < rclk; i++) begin
      half();
      sclk_out = 1'b1;
      rd = quad_in ? {rd[43:0], sio_in} : {rd[46:0], sio_in[1]};
      half();
      sclk_out = 1'b0;
    end
    half();
    cs_n_out = 1'b1;
    half();
  endtask
endmodule

/* File: verif/sfscr_regs_test.sv */
`timescale 1ns/1ps
module sfscr_regs_test;
  import sfscr_pkg::*;
  logic          sys_clk = 1'b0;
  logic          resetn = 1'b0;
  logic          quad = 1'b0;
  logic          wp_n = 1'b1;
  logic          rpin_n = 1'b1;
  logic          pe_req = 1'b0;
  logic          pe_chip = 1'b0;
  logic          pe_prot = 1'b0;
  logic          pe_done = 1'b0;
  logic          sclk;
  logic          cs_n;
  logic [3:0]    h_d;
  logic [3:0]    h_en;
  logic [3:0]    d_out;
  logic [3:0]    d_oe;
  logic          pe_start;
  logic          hardware_protect_mode;
  sfscr_status_t st;
  sfscr_config_t cf;
  int            n_errors = 0;
  int            num_checks = 0;
  wire [3:0]     sio_w = (d_oe & d_out) | (~d_oe & h_en & h_d) | (~d_oe & ~h_en);

  // 125 MHz system clock
  always #4 sys_clk = ~sys_clk;

  sfscr_host HOST (.clk_in(sys_clk), .quad_in(quad), .wp_n_in(wp_n), .sio_in(sio_w),
                   .sclk_out(sclk), .cs_n_out(cs_n), .sio_out(h_d), .sio_en_out(h_en));

  // Shorter write time, still long enough that a busy read fits inside it
  sfscr_regs #(.STATUS_WRITE_TIME_US(4)) DUT (
    .sys_clk_in(sys_clk), .resetn_in(resetn), .sclk_in(sclk), .cs_n_in(cs_n),
    .sio_in(sio_w), .sio_out(d_out), .sio_oe_out(d_oe), .quad_mode_in(quad),
    .reset_pin_n_in(rpin_n), .pe_req_in(pe_req), .pe_chip_erase_in(pe_chip),
    .pe_in_protected_in(pe_prot), .pe_done_in(pe_done), .pe_start_out(pe_start),
    .status_out(st), .config_out(cf), .hardware_protect_mode_out(hardware_protect_mode));

  task end_sim();
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  task cmd(input logic [7:0] op, input logic [15:0] wd, input int wbits);
    logic [47:0] r;
    HOST.xfer(op, wd, wbits, 0, r);
  endtask

  // Two copies in one frame: the byte must repeat
  task read_reg(input logic [7:0] op, input logic [7:0] exp);
    logic [47:0] r;
    HOST.xfer(op, 16'h0000, 0, quad ? 4 : 16, r);
    chk_byte(r[15:8], exp);
    chk_byte(r[7:0], exp);
  endtask

  // Poll busy until clear, then confirm the latch is clear too
  task poll_idle();
    logic [47:0] r;
    r = 48'h0000_0000_0001;
    for (int i = 0; i < 16 && r[0] !== 1'b0; i++) begin
      HOST.xfer(8'h05, 16'h0000, 0, 8, r);
    end
    chk_bit(r[0], 1'b0);
    chk_bit(r[1], 1'b0);
  endtask

  task pe_try(input logic chip, input logic prot, input logic exp);
    @(negedge sys_clk);
    pe_req = 1'b1;
    pe_chip = chip;
    pe_prot = prot;
    #1 chk_bit(pe_start, exp);
    @(negedge sys_clk);
    pe_req = 1'b0;
  endtask

  task t_reset();
    read_reg(8'h05, 8'h00);
    read_reg(8'h15, 8'h07);
  endtask

  task t_quad();
    logic [47:0] r;
    logic [7:0]  ids [3];
    ids = '{8'h5A, 8'h11, 8'h22};
    quad = 1'b1;
    HOST.xfer(QUAD_ID_OPCODE, 16'h0000, 0, 12, r);
    for (int i = 0; i < 6; i++) begin
      chk_byte(r[47 - 8 * i -: 8], ids[i % 3]);
    end
    read_reg(8'h05, 8'h00);
    quad = 1'b0;
  endtask

  task t_write();
    cmd(8'h01, 16'h3C00, 8);
    read_reg(8'h05, 8'h00);
    cmd(8'h06, 16'h0000, 0);
    read_reg(8'h05, 8'h02);
    cmd(8'h04, 16'h0000, 0);
    chk_byte(st, 8'h00);
    cmd(8'h06, 16'h0000, 0);
    cmd(8'h01, 16'h3C00, 12);
    read_reg(8'h05, 8'h02);
    cmd(8'h01, 16'h3CFD, 16);
    read_reg(8'h05, 8'h3F);
    read_reg(8'h15, 8'h0D);
    chk_byte(cf, 8'h0D);
    poll_idle();
    read_reg(8'h05, 8'h3C);
  endtask

  task t_array();
    cmd(8'h06, 16'h0000, 0);
    pe_try(1'b1, 1'b0, 1'b0);
    pe_try(1'b0, 1'b1, 1'b0);
    pe_try(1'b0, 1'b0, 1'b1);
    chk_byte(st, 8'h3F);
    pe_done = 1'b1;
    @(negedge sys_clk);
    pe_done = 1'b0;
    @(negedge sys_clk);
    chk_byte(st, 8'h3C);
    pe_try(1'b0, 1'b0, 1'b0);
  endtask

  task t_wide_lock();
    cmd(8'hB7, 16'h0000, 0);
    read_reg(8'h15, 8'h2D);
    cmd(8'hE9, 16'h0000, 0);
    read_reg(8'h15, 8'h0D);
    // Reset pin pulse clears latch and wide flag
    cmd(8'h06, 16'h0000, 0);
    cmd(8'hB7, 16'h0000, 0);
    rpin_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    rpin_n = 1'b1;
    chk_byte(cf, 8'h0D);
    chk_byte(st, 8'h3C);
    cmd(8'h06, 16'h0000, 0);
    cmd(8'h01, 16'h8000, 8);
    poll_idle();
    wp_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk_bit(hardware_protect_mode, 1'b1);
    cmd(8'h06, 16'h0000, 0);
    cmd(8'h01, 16'h0000, 8);
    read_reg(8'h05, 8'h82);
    // Quad enable masks the write-protect pin
    wp_n = 1'b1;
    cmd(8'h06, 16'h0000, 0);
    cmd(8'h01, 16'hC000, 8);
    poll_idle();
    wp_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk_bit(hardware_protect_mode, 1'b0);
    read_reg(8'h05, 8'hC0);
  endtask

  // Hang guard, well above the length of all scenarios
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (6) @(negedge sys_clk);
    t_reset();
    t_quad();
    t_write();
    t_array();
    t_wide_lock();
    end_sim();
  end
endmodule
